// ---- rtl/rrs_pkg.sv ----
package rrs_pkg;
  // ----------------------------------------------------------
  // Register map
  // ----------------------------------------------------------
  localparam int RRS_AW = 12;
  localparam logic [11:0] RRS_CAUSE_ADDR = 12'h000; // Cause/control
  localparam logic [11:0] RRS_STAT_ADDR = 12'h004; // Sequencer state
  localparam logic [15:0] RRS_CAUSE_POR = 16'h0003; // Power-on value
  localparam logic [15:0] RRS_CAUSE_MASK = 16'hc3ff; // Implemented
  // Cause/control bit positions
  localparam int B_TRAP = 15;
  localparam int B_OPC = 14;
  localparam int B_CFGM = 9;
  localparam int B_VREG = 8;
  localparam int B_PIN = 7;
  localparam int B_SOFT = 6;
  localparam int B_WDEN = 5;
  localparam int B_WATCHDOG_TIMEOUT_FLAG = 4;
  localparam int B_SLEEP = 3;
  localparam int B_IDLE = 2;
  localparam int B_BRWN = 1;
  localparam int B_POR = 0;
  // Sequencer state bit positions
  localparam int S_OSC = 0;  // Three bits of current selection
  localparam int S_EXEC = 3;
  localparam int S_MON = 4;
  localparam int S_FAIL = 5;
  localparam int S_MRST = 6;
  localparam int S_WDEN = 7;
  localparam int S_CLKV = 8;
  // ----------------------------------------------------------
  // Timing
  // ----------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int T_POR_NS = 10000;   // Power-on delay
  localparam int T_VREG_NS = 10000;  // Regulator startup
  localparam int T_RST_NS = 32000;   // State reset time
  localparam int POR_CYC = (T_POR_NS + CLK_NS - 1) / CLK_NS;
  localparam int VREG_CYC = (T_VREG_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_CYC = (T_RST_NS + CLK_NS - 1) / CLK_NS;
  localparam int MRW = 13;           // Release counter width
  localparam logic [9:0] STARTUP_LAST = 10'h3ff; // 1024th tick
  localparam logic [2:0] OSC_RC = 3'h0; // Fast internal RC code
  // Reset sequencer states
  typedef enum logic [1:0] {
    SEQ_POR = 2'b00,
    SEQ_HOLD = 2'b01,
    SEQ_RUN = 2'b10
  } rrs_seq_t;
endpackage

// ---- rtl/rrs_top.sv ----
// Our own choices: the register offsets and the AHB-Lite slave port.
module rrs_top #(
  parameter int POR_DLY = rrs_pkg::POR_CYC,
  parameter int VREG_DLY = rrs_pkg::VREG_CYC,
  parameter int RST_DLY = rrs_pkg::RST_CYC
) (
  // Clock and power-on reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Reset sources and instructions, one-cycle pulses; the pin and the idle select are levels
  input wire logic brownout_evt,
  input wire logic soft_reset_evt,
  input wire logic wdt_expire_evt,
  input wire logic trap_conflict_evt,
  input wire logic bad_opcode_evt,
  input wire logic config_mismatch_evt,
  input wire logic watchdog_clear_instr,
  input wire logic power_save_instr,
  input wire logic power_save_idle,
  input wire logic master_clear_pin_n,
  // Configuration and oscillator
  input wire logic watchdog_fuse,
  input wire logic clock_switch_en,
  input wire logic two_speed_en,
  input wire logic clk_mon_en,
  input wire logic [2:0] initial_osc_cfg,
  input wire logic osc_is_crystal,
  input wire logic osc_uses_pll,
  input wire logic osc_tick,
  input wire logic pll_lock,
  input wire logic in_low_power,
  // Outputs to the device
  output logic master_reset,
  output logic exec_enable,
  output logic [2:0] current_osc_sel,
  output logic [2:0] active_osc_sel,
  output logic watchdog_enable,
  output logic regulator_standby,
  output logic clk_mon_active
);
  import rrs_pkg::*;

  // ----------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------
  logic [1:0] pin_s_q;   // Master clear pin, active low
  logic [1:0] tick_s_q;  // Oscillator tick
  logic tick_d_q;        // Tick edge history
  logic [1:0] lock_s_q;  // PLL lock

  // Two flops each before any use
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s_q <= 2'h3;
      tick_s_q <= 2'h0;
      tick_d_q <= 1'b0;
      lock_s_q <= 2'h0;
    end else begin
      pin_s_q <= {pin_s_q[0], master_clear_pin_n};
      tick_s_q <= {tick_s_q[0], osc_tick};
      tick_d_q <= tick_s_q[1];
      lock_s_q <= {lock_s_q[0], pll_lock};
    end
  end

  wire logic pin_low = ~pin_s_q[1];
  wire logic tick_rise = tick_s_q[1] & ~tick_d_q;
  wire logic lock_ok = lock_s_q[1];

  // ----------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------
  logic wr_pend_q;               // Write data phase pending
  logic [RRS_AW-1:0] wr_addr_q;  // Its address
  logic [31:0] hrdata_q;         // Read data
  logic [15:0] cause_q;          // Cause/control register
  logic [15:0] stat_w;           // Sequencer state word

  // Address phase accepted
  wire logic addr_ok = hsel & htrans[1] & hready;
  wire logic [RRS_AW-1:0] a_lo = haddr[RRS_AW-1:0];
  wire logic hit_cause = (a_lo == RRS_CAUSE_ADDR);
  wire logic hit_stat = (a_lo == RRS_STAT_ADDR);
  // Read select, unmapped words read zero
  wire logic [31:0] rd_word =
    hit_cause ? {16'h0000, cause_q} :
    hit_stat ? {16'h0000, stat_w} : 32'h0000_0000;
  wire logic wr_cause = wr_pend_q & (wr_addr_q == RRS_CAUSE_ADDR);

  // Zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_ok & hwrite;
      wr_addr_q <= a_lo;
      // Read word latched at the address phase
      hrdata_q <= (addr_ok & ~hwrite) ? rd_word : 32'h0000_0000;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // ----------------------------------------------------------
  // Cause flags
  // ----------------------------------------------------------
  // Hardware set events per bit
  logic [15:0] hw_set;
  always_comb begin
    hw_set = 16'h0000;
    hw_set[B_TRAP] = trap_conflict_evt;
    hw_set[B_OPC] = bad_opcode_evt;
    hw_set[B_CFGM] = config_mismatch_evt;
    hw_set[B_PIN] = pin_low;
    hw_set[B_SOFT] = soft_reset_evt;
    hw_set[B_WATCHDOG_TIMEOUT_FLAG] = wdt_expire_evt;
    hw_set[B_SLEEP] = power_save_instr & ~power_save_idle;
    hw_set[B_IDLE] = power_save_instr & power_save_idle;
    hw_set[B_BRWN] = brownout_evt;
  end

  // Watchdog flag cleared by clear or power-save instruction
  wire logic watchdog_timeout_flag_clr = watchdog_clear_instr | power_save_instr;
  wire logic [15:0] sw_val = wr_cause ? hwdata[15:0] : cause_q;
  wire logic [15:0] clr_mask = {11'h000, watchdog_timeout_flag_clr, 4'h0};
  // Set beats clear and write; unimplemented bits forced zero
  wire logic [15:0] cause_d =
    ((sw_val & ~clr_mask) | hw_set) & RRS_CAUSE_MASK;

  // Power-on value; other resets keep the flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cause_q <= RRS_CAUSE_POR;
    end else begin
      cause_q <= cause_d;
    end
  end

  // ----------------------------------------------------------
  // Master reset sequencing
  // ----------------------------------------------------------
  rrs_seq_t seq_q;
  rrs_seq_t seq_d;
  logic [MRW-1:0] dly_q;  // Remaining hold cycles
  logic [MRW-1:0] dly_d;
  logic mrst_q;           // Master reset out

  // Any active source; register writes are not one
  wire logic src_any = brownout_evt | soft_reset_evt |
    wdt_expire_evt | trap_conflict_evt | bad_opcode_evt |
    config_mismatch_evt | pin_low;
  wire logic [MRW-1:0] dly_por = MRW'(POR_DLY + VREG_DLY + RST_DLY);
  wire logic [MRW-1:0] dly_bor = MRW'(VREG_DLY + RST_DLY);
  wire logic [MRW-1:0] dly_rst = MRW'(RST_DLY);
  // Brownout path is longer than plain state reset
  wire logic [MRW-1:0] dly_src = brownout_evt ? dly_bor : dly_rst;

  // Next state of the sequencer
  always_comb begin
    seq_d = seq_q;
    dly_d = dly_q;
    case (seq_q)
      SEQ_POR: begin
        seq_d = SEQ_HOLD;
        dly_d = dly_por;
      end
      SEQ_HOLD: begin
        if (src_any) begin
          dly_d = dly_src;
        end else if (dly_q <= MRW'(1)) begin
          seq_d = SEQ_RUN;
          dly_d = '0;
        end else begin
          dly_d = dly_q - MRW'(1);
        end
      end
      SEQ_RUN: begin
        if (src_any) begin
          seq_d = SEQ_HOLD;
          dly_d = dly_src;
        end
      end
      default: begin
        seq_d = SEQ_POR;
        dly_d = '0;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_q <= SEQ_POR;
      dly_q <= '0;
      mrst_q <= 1'b1;
    end else begin
      seq_q <= seq_d;
      dly_q <= dly_d;
      mrst_q <= (seq_d != SEQ_RUN);
    end
  end

  wire logic rst_start = (seq_q == SEQ_POR) | src_any;
  wire logic release_now = mrst_q & (seq_d == SEQ_RUN);

  // ----------------------------------------------------------
  // Oscillator startup and clock selection
  // ----------------------------------------------------------
  logic [9:0] sut_q;   // Startup tick count
  logic sut_done_q;
  logic [2:0] osc_q;   // Current oscillator selection
  logic [2:0] osc_d;
  logic mon_q;         // Monitor running
  logic fail_q;        // Monitor moved to RC
  logic exec_q;
  logic [2:0] act_q;

  // Startup timer restarts with every reset, runs in parallel
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sut_q <= 10'h000;
      sut_done_q <= 1'b0;
    end else if (rst_start) begin
      sut_q <= 10'h000;
      sut_done_q <= 1'b0;
    end else if (tick_rise & ~sut_done_q) begin
      sut_q <= sut_q + 10'h001;
      sut_done_q <= (sut_q == STARTUP_LAST);
    end
  end

  // Primary ready: crystal timer and PLL lock as needed
  wire logic prim_ok = (~osc_is_crystal | sut_done_q) &
    (~osc_uses_pll | lock_ok);
  wire logic on_rc = (osc_q == OSC_RC);
  // Two-speed runs on RC until primary is ready
  wire logic use_rc = fail_q | on_rc |
    (two_speed_en & ~prim_ok);
  wire logic clk_ok = use_rc | prim_ok;
  wire logic load_cfg = (seq_q == SEQ_POR) | brownout_evt |
    (~clock_switch_en & src_any);
  wire logic mon_trip = mon_q & ~prim_ok & ~on_rc;

  // Selection source by reset type
  always_comb begin
    osc_d = osc_q;
    if (load_cfg) begin
      osc_d = initial_osc_cfg;
    end else if (mon_trip) begin
      osc_d = OSC_RC;
    end
  end

  // Selection, monitor and execution gate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_q <= OSC_RC;
      mon_q <= 1'b0;
      fail_q <= 1'b0;
      exec_q <= 1'b0;
      act_q <= OSC_RC;
    end else begin
      osc_q <= osc_d;
      // Monitor begins at master reset release
      if (rst_start) begin
        mon_q <= 1'b0;
      end else if (release_now) begin
        mon_q <= clk_mon_en;
      end
      if (load_cfg) begin
        fail_q <= 1'b0;
      end else if (mon_trip) begin
        fail_q <= 1'b1;
      end
      exec_q <= ~mrst_q & clk_ok & ~rst_start;
      act_q <= use_rc ? OSC_RC : osc_q;
    end
  end

  // ----------------------------------------------------------
  // Watchdog enable and regulator standby
  // ----------------------------------------------------------
  logic wden_q;
  logic vstby_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wden_q <= 1'b0;
      vstby_q <= 1'b0;
    end else begin
      wden_q <= watchdog_fuse | cause_q[B_WDEN];
      vstby_q <= in_low_power & ~cause_q[B_VREG];
    end
  end

  // State word for software
  assign stat_w = {7'h00, clk_ok, wden_q, mrst_q, fail_q, mon_q,
    exec_q, osc_q};

  assign master_reset = mrst_q;
  assign exec_enable = exec_q;
  assign current_osc_sel = osc_q;
  assign active_osc_sel = act_q;
  assign watchdog_enable = wden_q;
  assign regulator_standby = vstby_q;
  assign clk_mon_active = mon_q;

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_trap;
    trap_conflict_evt |=> cause_q[B_TRAP];
  endproperty
  a_trap: assert property (p_trap)
    else $error("trap flag not set");
  property p_opc;
    bad_opcode_evt |=> cause_q[B_OPC];
  endproperty
  a_opc: assert property (p_opc)
    else $error("bad opcode flag not set");
  property p_unimpl;
    addr_ok & ~hwrite & hit_cause |=> hrdata_q[13:10] == 4'h0;
  endproperty
  a_unimpl: assert property (p_unimpl)
    else $error("unimplemented bits read nonzero");
  property p_cm;
    config_mismatch_evt |=> cause_q[B_CFGM];
  endproperty
  a_cm: assert property (p_cm)
    else $error("mismatch flag not set");
  property p_vreg;
    in_low_power & ~cause_q[B_VREG] |=> regulator_standby;
  endproperty
  a_vreg: assert property (p_vreg)
    else $error("regulator did not enter standby");
  property p_pin;
    pin_low |=> cause_q[B_PIN] && master_reset;
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin reset not recorded");
  property p_soft;
    soft_reset_evt |=> cause_q[B_SOFT];
  endproperty
  a_soft: assert property (p_soft)
    else $error("soft reset flag not set");
  property p_wden;
    watchdog_fuse |=> watchdog_enable;
  endproperty
  a_wden: assert property (p_wden)
    else $error("fuse did not force watchdog");
  property p_watchdog_timeout_flag;
    watchdog_timeout_flag_clr & ~wdt_expire_evt |=> ~cause_q[B_WATCHDOG_TIMEOUT_FLAG];
  endproperty
  a_watchdog_timeout_flag: assert property (p_watchdog_timeout_flag)
    else $error("watchdog flag not cleared");
  property p_sleep;
    power_save_instr & ~power_save_idle |=> cause_q[B_SLEEP];
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep flag not set");
  property p_idle;
    power_save_instr & power_save_idle |=> cause_q[B_IDLE];
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle flag not set");
  property p_nowr;
    seq_q == SEQ_RUN && wr_cause && !src_any |=> !master_reset;
  endproperty
  a_nowr: assert property (p_nowr)
    else $error("flag write started a reset");
  property p_rstdly;
    seq_q == SEQ_RUN && soft_reset_evt && !brownout_evt
      |=> dly_q == dly_rst;
  endproperty
  a_rstdly: assert property (p_rstdly)
    else $error("wrong release delay");
  property p_exec;
    exec_enable |-> !master_reset && $past(clk_ok);
  endproperty
  a_exec: assert property (p_exec)
    else $error("execution without valid clock");
  property p_mon;
    mon_trip && !load_cfg |=> current_osc_sel == OSC_RC;
  endproperty
  a_mon: assert property (p_mon)
    else $error("monitor did not switch to rc");
  property p_setwin;
    wr_cause && !hwdata[B_TRAP] && trap_conflict_evt
      |=> cause_q[B_TRAP];
  endproperty
  a_setwin: assert property (p_setwin)
    else $error("software write beat hardware set");

endmodule // rrs_top

// ---- test/rrs_src_model.sv ----
// ----------------------------------------
// Core and reset source model
// ----------------------------------------
module rrs_src_model (
  // Clock
  input wire logic hclk,
  // One-hot request from the bench
  input wire logic [7:0] req,
  // Pulses into the block
  output logic trap_conflict_evt,
  output logic bad_opcode_evt,
  output logic config_mismatch_evt,
  output logic soft_reset_evt,
  output logic wdt_expire_evt,
  output logic brownout_evt,
  output logic watchdog_clear_instr,
  output logic power_save_instr,
  // Oscillator side
  output logic osc_tick,
  output logic pll_lock
);
  logic [1:0] div_q = 2'h0; // Tick divider

  // Each request becomes a one-cycle pulse
  always_ff @(posedge hclk) begin
    {power_save_instr, watchdog_clear_instr, brownout_evt,
     wdt_expire_evt, soft_reset_evt, config_mismatch_evt,
     bad_opcode_evt, trap_conflict_evt} <= req;
  end

  // Oscillator rises once every four bus cycles
  always_ff @(posedge hclk) begin
    div_q <= div_q + 2'h1;
  end
  assign osc_tick = div_q[1];
  assign pll_lock = 1'b1; // Lock is held
endmodule // rrs_src_model

// ---- test/rrs_top_tb.sv ----
module rrs_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rrs_pkg::*;
  localparam int PD = 4, VD = 4, RD = 8;
  // Stimulus
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [7:0] req = 8'h0;
  logic pin_n = 1'b1, ps_idle = 1'b0, fuse = 1'b0, csw = 1'b1;
  logic two = 1'b0, xtal = 1'b0, lowp = 1'b1, rd_ph = 1'b0;
  logic mon_en = 1'b0;
  logic [2:0] cfg = 3'h1, c1, c2;
  // Observed
  logic hreadyout, hresp, mrst, exec, wden, vstby, mon;
  logic [31:0] hrdata;
  logic [2:0] cur, act;
  logic tr, op, cm, sr, wd, bo, wc, ps, tick, lock;
  logic [31:0] exp_q[$];
  int errors = 0, n_tests = 0, n;
  int bt[6] = '{15, 14, 9, 6, 4, 1};

  always #5 hclk = ~hclk;

  rrs_src_model i_src (.hclk(hclk), .req(req),
    .trap_conflict_evt(tr), .bad_opcode_evt(op),
    .config_mismatch_evt(cm), .soft_reset_evt(sr),
    .wdt_expire_evt(wd), .brownout_evt(bo),
    .watchdog_clear_instr(wc), .power_save_instr(ps),
    .osc_tick(tick), .pll_lock(lock));

  rrs_top #(.POR_DLY(PD), .VREG_DLY(VD), .RST_DLY(RD)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .brownout_evt(bo),
    .soft_reset_evt(sr), .wdt_expire_evt(wd),
    .trap_conflict_evt(tr), .bad_opcode_evt(op),
    .config_mismatch_evt(cm), .watchdog_clear_instr(wc),
    .power_save_instr(ps), .power_save_idle(ps_idle),
    .master_clear_pin_n(pin_n), .watchdog_fuse(fuse),
    .clock_switch_en(csw), .two_speed_en(two), .clk_mon_en(mon_en),
    .initial_osc_cfg(cfg), .osc_is_crystal(xtal),
    .osc_uses_pll(1'b0), .osc_tick(tick), .pll_lock(lock),
    .in_low_power(lowp), .master_reset(mrst), .exec_enable(exec),
    .current_osc_sel(cur), .active_osc_sel(act),
    .watchdog_enable(wden), .regulator_standby(vstby),
    .clk_mon_active(mon));

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    n_tests++;
    if (e !== s) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask

  task automatic give_verdict;
    $display("Checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Read data taken at the data phase edge
  always @(posedge hclk) begin
    if (rd_ph && hreadyout) begin
      chk("hresp", 32'h0, {31'h0, hresp});
      chk("hrdata", exp_q.pop_front(), hrdata);
    end
  end

  // One AHB single transfer
  task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_ph <= 1'b0;
  endtask

  task automatic rd(logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, RRS_CAUSE_ADDR, 32'h0);
  endtask

  // Wait for master reset release, counting cycles
  task automatic rel();
    n = 0;
    while (mrst !== 1'b0 && n < 20000) begin
      @(posedge hclk);
      n++;
    end
  endtask

  // Pulse one source, check assertion and release time
  task automatic fire(int i, int d);
    req <= 8'h1 << i;
    @(posedge hclk);
    req <= 8'h0;
    if (i > 5) begin
      // Let the pulse reach the flags before any read
      repeat (2) @(posedge hclk);
      return;
    end
    repeat (3) @(posedge hclk);
    chk("mrst_on", 32'h1, {31'h0, mrst});
    rel();
    chk("mrst_len", 32'h1, 32'(n >= d - 4 && n <= d));
    repeat (3) @(posedge hclk);
    chk("exec", 32'h1, {31'h0, exec});
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(22504));
    c1 = 3'($urandom_range(7, 1));
    c2 = (c1 == 3'h7) ? 3'h1 : c1 + 3'h1;
    cfg = c1;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rel();
    chk("por_len", 32'h1, 32'(n >= PD + VD + RD - 2));
    rd(32'h3);
    chk("osc_por", c1, cur);
    // Random write: no reset, holes read zero
    hwdata <= $urandom;
    @(posedge hclk);
    bus(1'b1, RRS_CAUSE_ADDR, hwdata);
    rd(hwdata & 32'hc3ff);
    repeat (2) @(posedge hclk);
    chk("no_rst", 32'h0, {31'h0, mrst});
    chk("wden", hwdata[5], wden);
    chk("vstby", !hwdata[8], vstby);
    fuse <= 1'b1;
    bus(1'b1, RRS_CAUSE_ADDR, 32'h0);
    rd(32'h0);
    chk("wd_fuse", 32'h1, {31'h0, wden});
    // Each pulsed reset source sets its own flag
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, RRS_CAUSE_ADDR, 32'h0);
      fire(i, (i == 5) ? VD + RD : RD);
      rd(32'h1 << bt[i]);
    end
    // Pin reset
    bus(1'b1, RRS_CAUSE_ADDR, 32'h0);
    pin_n <= 1'b0;
    repeat (4) @(posedge hclk);
    pin_n <= 1'b1;
    rel();
    rd(32'h80);
    // Power save and watchdog clear
    bus(1'b1, RRS_CAUSE_ADDR, 32'h10);
    fire(7, 0);
    rd(32'h8);
    bus(1'b1, RRS_CAUSE_ADDR, 32'h10);
    fire(6, 0);
    rd(32'h0);
    ps_idle <= 1'b1;
    fire(7, 0);
    rd(32'h4);
    // Clock source choice on soft reset, by clock switch enable
    cfg <= c2;
    fire(3, RD);
    chk("osc_keep", c1, cur);
    csw <= 1'b0;
    fire(3, RD);
    chk("osc_cfg", c2, cur);
    // Crystal power-up: execution waits on startup timer
    xtal <= 1'b1;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    n = 0;
    while (exec !== 1'b1 && n < 6000) begin
      @(posedge hclk);
      n++;
    end
    chk("ost", 32'h1, 32'(n >= 4080 && n <= 4120));
    rd(32'h3);
    // Two-speed start runs on RC first
    two <= 1'b1;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rel();
    repeat (4) @(posedge hclk);
    chk("two_rc", OSC_RC, act);
    repeat (4200) @(posedge hclk);
    chk("two_pri", c2, act);
    // Clock monitor falls back to RC when crystal is late
    mon_en <= 1'b1;
    two <= 1'b0;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rel();
    repeat (4) @(posedge hclk);
    chk("mon_on", 32'h1, {31'h0, mon});
    chk("mon_rc", OSC_RC, cur);
    give_verdict();
  end

  // Hang guard
  initial begin
    #400000;
    errors++;
    give_verdict();
  end
endmodule // rrs_top_tb
